// ===== core/rmsc_top.sv
// reset pin, reset cause, mode select and debug pin control
//
// Chosen here: the placing of the registers and the APB register port.
`include "rmsc_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module rmsc_top (
    input  wire logic                   ref_clk,
    input  wire logic                   reset_n,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire rmsc_pkg::rmsc_rst_req_t rst_req,
    input  wire logic                   rst_pin_in,
    output logic                        rst_pin_out,
    output logic                        rst_pin_oe,
    input  wire logic                   dbg_pin_in,
    output logic                        dbg_pin_out,
    output logic                        dbg_pin_oe,
    input  wire logic                   lclk_tick,
    input  wire logic                   bdc_background,
    input  wire logic                   bdc_go,
    output logic                        bus_clk,
    output logic                        sys_reset_n,
    output logic                        clk_src_ext,
    output logic                        cpu_halt,
    output logic                        vector_fetch,
    output logic      [15:0]            vector_addr
);
    import rmsc_pkg::*;

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    rmsc_state_t state;
    rmsc_state_t next_state;
    rmsc_cause_t cause;
    rmsc_cause_t next_cause;
    logic [6:0]  rst_cnt;
    logic [6:0]  next_rst_cnt;
    logic        next_bus_clk;
    logic        bus_tick;
    logic        next_bdm;
    logic        next_ext;
    logic        lclk_sel;
    logic        next_lclk_sel;
    logic        next_vfetch;
    logic        next_sys_reset_n;
    logic        tx_busy;
    logic        next_tx_busy;
    logic        tx_val;
    logic        next_tx_val;
    logic [3:0]  tx_cnt;
    logic [3:0]  next_tx_cnt;
    logic        bdc_tick;
    logic        next_dbg_out;
    logic        next_dbg_oe;
    logic        next_rst_oe;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic        acc_wr;
    logic        force_req;
    logic        tx_req;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
        return a == r;
    endfunction

    // ticks the line is pulled low for a one or a zero
    function automatic logic [3:0] low_ticks(input logic v);
        return v ? `RMSC_BDC_LOW_ONE : `RMSC_BDC_LOW_ZERO;
    endfunction

    // -----------------------------------------------------------------
    // bus clock divider and debug clock select
    // -----------------------------------------------------------------
    assign bus_tick = bus_clk;
    assign bdc_tick = lclk_sel ? lclk_tick : bus_tick;

    // -----------------------------------------------------------------
    // apb slave, zero wait states
    // -----------------------------------------------------------------
    assign acc_wr    = psel && penable && pready && pwrite;
    assign force_req = acc_wr && hit(paddr, `RMSC_ADDR_FORCE)
                       && pwdata[`RMSC_FORCE_BIT];
    assign tx_req    = acc_wr && hit(paddr, `RMSC_ADDR_BDCTX) && !tx_busy;

    always_comb begin
        next_pready  = psel && !penable;
        next_pslverr = 1'b0;
        next_prdata  = 32'h0000_0000;
        if (psel && !penable) begin
            if (hit(paddr, `RMSC_ADDR_CAUSE)) begin
                next_prdata[7:0] = cause;
            end else if (hit(paddr, `RMSC_ADDR_FORCE)) begin
                next_prdata = 32'h0000_0000;
            end else if (hit(paddr, `RMSC_ADDR_CTRL)) begin
                next_prdata[`RMSC_CTRL_EXT_CLK]  = clk_src_ext;
                next_prdata[`RMSC_CTRL_LCLK_SEL] = lclk_sel;
                next_prdata[`RMSC_CTRL_BDM]      = cpu_halt;
            end else if (hit(paddr, `RMSC_ADDR_BDCTX)) begin
                next_prdata[`RMSC_TX_VAL]  = tx_val;
                next_prdata[`RMSC_TX_BUSY] = tx_busy;
            end else begin
                next_pslverr = 1'b1;
            end
        end
    end

    // -----------------------------------------------------------------
    // reset sequencer
    // -----------------------------------------------------------------
    always_comb begin
        next_state       = state;
        next_cause       = cause;
        next_rst_cnt     = rst_cnt;
        next_bus_clk     = !bus_clk;
        next_bdm         = cpu_halt;
        next_ext         = clk_src_ext;
        next_lclk_sel    = lclk_sel;
        next_vfetch      = 1'b0;
        next_sys_reset_n = sys_reset_n;
        unique case (state)
            ST_RUN: begin
                if (bdc_background) begin
                    next_bdm = 1'b1;
                end else if (bdc_go) begin
                    next_bdm = 1'b0;
                end
                if (acc_wr && hit(paddr, `RMSC_ADDR_CTRL)) begin
                    next_ext      = pwdata[`RMSC_CTRL_EXT_CLK];
                    next_lclk_sel = pwdata[`RMSC_CTRL_LCLK_SEL];
                end
                if (!rst_pin_in || force_req || (|rst_req)) begin
                    next_state       = ST_DRIVE;
                    next_rst_cnt     = 7'd0;
                    next_sys_reset_n = 1'b0;
                    next_cause       = `RMSC_CAUSE_NONE;
                    next_cause.pin   = !rst_pin_in;
                    next_cause.dbgfr = force_req;
                    next_cause.wdog  = rst_req.wdog;
                    next_cause.ilop  = rst_req.ilop;
                    next_cause.ilad  = rst_req.ilad;
                    next_cause.lvd   = rst_req.lvd;
                end
            end
            ST_DRIVE: begin
                next_sys_reset_n = 1'b0;
                next_ext         = 1'b0;
                next_lclk_sel    = 1'b0;
                if (bus_tick) begin
                    if (rst_cnt == `RMSC_RST_BUS_CYCLES - 7'd1) begin
                        next_state = ST_SAMPLE;
                    end else begin
                        next_rst_cnt = rst_cnt + 7'd1;
                    end
                end
            end
            ST_SAMPLE: begin
                // wait for any outside hold on the reset pin to end
                if (rst_pin_in) begin
                    next_state       = ST_RUN;
                    next_sys_reset_n = 1'b1;
                    // pin reset never selects background
                    next_bdm = !dbg_pin_in
                               && (cause.por || cause.dbgfr)
                               && !cause.pin;
                    next_vfetch = dbg_pin_in || cause.pin
                                  || !(cause.por || cause.dbgfr);
                end
            end
            default: begin
                next_state = ST_DRIVE;
            end
        endcase
    end

    assign next_rst_oe = (next_state == ST_DRIVE);

    // -----------------------------------------------------------------
    // single-wire debug bit transmitter
    // -----------------------------------------------------------------
    always_comb begin
        next_tx_busy = tx_busy;
        next_tx_val  = tx_val;
        next_tx_cnt  = tx_cnt;
        next_dbg_out = 1'b0;
        next_dbg_oe  = 1'b0;
        if (next_state != ST_RUN) begin
            next_tx_busy = 1'b0;
        end else if (tx_busy) begin
            if (bdc_tick) begin
                if (tx_cnt == `RMSC_BDC_BIT_LAST) begin
                    next_tx_busy = 1'b0;
                end else begin
                    next_tx_cnt = tx_cnt + 4'd1;
                end
            end
        end else if (tx_req) begin
            next_tx_busy = 1'b1;
            next_tx_val  = pwdata[`RMSC_TX_VAL];
            next_tx_cnt  = 4'd0;
        end
        if (next_state == ST_RUN && next_tx_busy) begin
            if (next_tx_cnt < low_ticks(next_tx_val)) begin
                next_dbg_oe = 1'b1;
            end else if (next_tx_cnt == low_ticks(next_tx_val)) begin
                next_dbg_oe  = 1'b1;
                next_dbg_out = 1'b1;
            end
        end
    end

    // -----------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state        <= ST_DRIVE;
            cause        <= `RMSC_CAUSE_POR;
            rst_cnt      <= 7'd0;
            bus_clk      <= 1'b0;
            cpu_halt     <= 1'b0;
            clk_src_ext  <= 1'b0;
            lclk_sel     <= 1'b0;
            vector_fetch <= 1'b0;
            sys_reset_n  <= 1'b0;
            rst_pin_oe   <= 1'b1;
            tx_busy      <= 1'b0;
            tx_val       <= 1'b0;
            tx_cnt       <= 4'd0;
            dbg_pin_out  <= 1'b0;
            dbg_pin_oe   <= 1'b0;
            prdata       <= 32'h0000_0000;
            pready       <= 1'b0;
            pslverr      <= 1'b0;
        end else begin
            state        <= next_state;
            cause        <= next_cause;
            rst_cnt      <= next_rst_cnt;
            bus_clk      <= next_bus_clk;
            cpu_halt     <= next_bdm;
            clk_src_ext  <= next_ext;
            lclk_sel     <= next_lclk_sel;
            vector_fetch <= next_vfetch;
            sys_reset_n  <= next_sys_reset_n;
            rst_pin_oe   <= next_rst_oe;
            tx_busy      <= next_tx_busy;
            tx_val       <= next_tx_val;
            tx_cnt       <= next_tx_cnt;
            dbg_pin_out  <= next_dbg_out;
            dbg_pin_oe   <= next_dbg_oe;
            prdata       <= next_prdata;
            pready       <= next_pready;
            pslverr      <= next_pslverr;
        end
    end

    // open-drain reset pin only ever pulls low
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_pin_out <= 1'b0;
            vector_addr <= `RMSC_VECTOR_ADDR;
        end else begin
            rst_pin_out <= 1'b0;
            vector_addr <= `RMSC_VECTOR_ADDR;
        end
    end

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    logic [7:0] hold_len;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            hold_len <= 8'd0;
        end else if (!rst_pin_oe) begin
            hold_len <= 8'd0;
        end else if (hold_len != 8'hff) begin
            hold_len <= hold_len + 8'd1;
        end
    end

    property p_hold_len;
        @(posedge ref_clk) disable iff (!reset_n)
        $fell(rst_pin_oe) |-> ($past(hold_len) >= `RMSC_HOLD_MIN
                               && $past(hold_len) <= `RMSC_HOLD_MAX);
    endproperty
    a_hold_len: assert property (p_hold_len) else $error("reset pulse length wrong");

    property p_pin_cause;
        @(posedge ref_clk) disable iff (!reset_n)
        (state == ST_RUN && !rst_pin_in && !force_req && !(|rst_req))
            |=> (cause.pin && !cause.por && !cause.dbgfr) ##1 rst_pin_oe;
    endproperty
    a_pin_cause: assert property (p_pin_cause) else $error("pin reset cause not kept");

    property p_pin_input;
        @(posedge ref_clk) disable iff (!reset_n)
        (state != ST_RUN) |-> !dbg_pin_oe;
    endproperty
    a_pin_input: assert property (p_pin_input) else $error("mode pin driven in reset");

    property p_normal;
        @(posedge ref_clk) disable iff (!reset_n)
        (state == ST_SAMPLE && rst_pin_in && dbg_pin_in)
            |=> (!cpu_halt && vector_fetch && sys_reset_n) ##1 !vector_fetch;
    endproperty
    a_normal: assert property (p_normal) else $error("normal mode not entered");

    property p_background;
        @(posedge ref_clk) disable iff (!reset_n)
        (state == ST_SAMPLE && rst_pin_in && !dbg_pin_in && !cause.pin
         && (cause.por || cause.dbgfr)) |=> (cpu_halt && !vector_fetch);
    endproperty
    a_background: assert property (p_background) else $error("background not entered");

    property p_pin_user;
        @(posedge ref_clk) disable iff (!reset_n)
        (state == ST_SAMPLE && rst_pin_in && cause.pin) |=> !cpu_halt;
    endproperty
    a_pin_user: assert property (p_pin_user) else $error("pin reset entered background");

    property p_half_rate;
        @(posedge ref_clk) disable iff (!reset_n)
        bus_clk |=> !bus_clk ##1 bus_clk;
    endproperty
    a_half_rate: assert property (p_half_rate) else $error("bus clock not half rate");

    property p_int_clock;
        @(posedge ref_clk) disable iff (!reset_n)
        $rose(sys_reset_n) |-> !clk_src_ext && !lclk_sel;
    endproperty
    a_int_clock: assert property (p_int_clock) else $error("external clock after reset");

    property p_release;
        @(posedge ref_clk) disable iff (!reset_n)
        (state == ST_DRIVE) |-> !sys_reset_n && rst_cnt < `RMSC_RST_BUS_CYCLES;
    endproperty
    a_release: assert property (p_release) else $error("reset released early");

    c_bdm_entry: cover property (@(posedge ref_clk) disable iff (!reset_n) $rose(cpu_halt));
    c_pin_reset: cover property (@(posedge ref_clk) disable iff (!reset_n)
                                 state == ST_SAMPLE && cause.pin);
    c_force:     cover property (@(posedge ref_clk) disable iff (!reset_n) force_req);
    c_speedup:   cover property (@(posedge ref_clk) disable iff (!reset_n)
                                 dbg_pin_oe && dbg_pin_out);

endmodule

`default_nettype wire

// ===== core/rmsc_defs.svh
// constants for the reset and mode-select control block
`ifndef RMSC_DEFS_SVH
`define RMSC_DEFS_SVH

// -----------------------------------------------------------------
// reset pulse timing: length in bus clock cycles, hold bounds in ref_clk cycles
// -----------------------------------------------------------------
`define RMSC_RST_BUS_CYCLES   7'd66
`define RMSC_HOLD_MIN         8'd130
`define RMSC_HOLD_MAX         8'd134

// -----------------------------------------------------------------
// single-wire debug bit timing, in debug clock ticks
// -----------------------------------------------------------------
`define RMSC_BDC_BIT_LAST     4'd15
`define RMSC_BDC_LOW_ONE      4'd4
`define RMSC_BDC_LOW_ZERO     4'd13

// -----------------------------------------------------------------
// register byte addresses
// -----------------------------------------------------------------
`define RMSC_ADDR_CAUSE       12'h000
`define RMSC_ADDR_FORCE       12'h004
`define RMSC_ADDR_CTRL        12'h008
`define RMSC_ADDR_BDCTX       12'h00c

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define RMSC_FORCE_BIT        0
`define RMSC_CTRL_EXT_CLK     0
`define RMSC_CTRL_LCLK_SEL    1
`define RMSC_CTRL_BDM         2
`define RMSC_TX_VAL           0
`define RMSC_TX_BUSY          1

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define RMSC_VECTOR_ADDR      16'hfffe
`define RMSC_CAUSE_POR        8'h80
`define RMSC_CAUSE_NONE       8'h00

`endif

// ===== core/rmsc_pkg.sv
// types shared by the reset and mode-select control block
package rmsc_pkg;

    // -----------------------------------------------------------------
    // sequencer states
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_RUN    = 2'b00,
        ST_DRIVE  = 2'b01,
        ST_SAMPLE = 2'b10
    } rmsc_state_t;

    // -----------------------------------------------------------------
    // reset cause register layout, msb first
    // -----------------------------------------------------------------
    typedef struct packed {
        logic por;
        logic pin;
        logic wdog;
        logic ilop;
        logic ilad;
        logic dbgfr;
        logic lvd;
        logic rsv;
    } rmsc_cause_t;

    // -----------------------------------------------------------------
    // internal reset requests from other units
    // -----------------------------------------------------------------
    typedef struct packed {
        logic wdog;
        logic ilop;
        logic ilad;
        logic lvd;
    } rmsc_rst_req_t;

endpackage

// ===== test/rmsc_pod.sv
// debug pod and board reset source facing the reset and mode-select block
`timescale 1ns/1ps
`default_nettype none

module rmsc_pod (
    input  wire logic ref_clk,
    input  wire logic rst_pin_oe,
    input  wire logic dbg_pin_oe,
    input  wire logic dbg_pin_out,
    input  wire logic pull_rst,
    input  wire logic hold_ms,
    output logic      rst_pin,
    output logic      dbg_pin
);
    logic hold_q;
    logic speedup;

    always_ff @(posedge ref_clk) begin
        hold_q <= hold_ms;
    end

    // one cycle of active high drive as the pod lets go of the line
    assign speedup = hold_q & ~hold_ms;

    // open drain line with pull-up: low while either side pulls
    assign rst_pin = (rst_pin_oe | pull_rst) ? 1'b0 : 1'b1;

    // pod holds the mode line low to ask for background, else pull-up
    assign dbg_pin = dbg_pin_oe ? dbg_pin_out : speedup ? 1'b1 : hold_ms ? 1'b0 : 1'b1;
endmodule

`default_nettype wire

// ===== test/testbench.sv
// self-checking bench for the reset and mode-select block
`include "rmsc_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import rmsc_pkg::*;
    logic          ref_clk, reset_n, psel, penable, pwrite, pready, pslverr, e, b;
    logic [11:0]   paddr;
    logic [31:0]   pwdata, prdata, q;
    rmsc_rst_req_t rst_req;
    logic          rst_pin, rst_oe, rst_out, dbg_pin, dbg_oe, dbg_out;
    logic          lclk_tick = 1'b0;
    logic          bdc_bg, bdc_go, bus_clk, sys_reset_n, clk_src_ext, cpu_halt;
    logic          vector_fetch, pull_rst, hold_ms;
    logic [15:0]   vector_addr;
    logic [1:0]    lc = 2'd0;
    logic [7:0]    cz [4];
    int            fails = 0;
    int            checked = 0;
    int            low_n = 0;
    int            spd_n = 0;
    int            vf_n = 0;

    rmsc_top dut (.ref_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .rst_req, .rst_pin_in(rst_pin), .rst_pin_out(rst_out),
        .rst_pin_oe(rst_oe), .dbg_pin_in(dbg_pin), .dbg_pin_out(dbg_out),
        .dbg_pin_oe(dbg_oe), .lclk_tick, .bdc_background(bdc_bg), .bdc_go, .bus_clk,
        .sys_reset_n, .clk_src_ext, .cpu_halt, .vector_fetch, .vector_addr);

    rmsc_pod pod (.ref_clk, .rst_pin_oe(rst_oe), .dbg_pin_oe(dbg_oe),
        .dbg_pin_out(dbg_out), .pull_rst, .hold_ms, .rst_pin, .dbg_pin);

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // -----------------------------------------------------------------
    // low-speed tick and line monitors
    // -----------------------------------------------------------------
    always @(posedge ref_clk) begin
        lc <= lc + 2'd1;
        lclk_tick <= (lc == 2'd3);
        if (vector_fetch === 1'b1) vf_n <= vf_n + 1;
        if (dbg_oe === 1'b1 && dbg_out === 1'b0) low_n <= low_n + 1;
        if (dbg_oe === 1'b1 && dbg_out === 1'b1) spd_n <= spd_n + 1;
    end

    task chk(input string n, input logic [31:0] x, input logic [31:0] g);
        checked++;
        if (g !== x) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, x, g);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_rst(input logic [7:0] cause, input logic halt);
        int n;
        int v0;
        logic d;
        logic r;
        n = 0;
        d = 1'b0;
        r = 1'b0;
        v0 = vf_n;
        while (rst_oe !== 1'b1 && n < 20) begin
            @(posedge ref_clk);
            n++;
        end
        n = 0;
        while (rst_oe === 1'b1 && n < 300) begin
            @(posedge ref_clk);
            n++;
            d = d | dbg_oe;
            r = r | sys_reset_n;
        end
        chk("pulse_len", 1, n >= 130 && n <= 134);
        chk("mode_pin_undriven", 0, d);
        chk("held_in_reset", 0, r);
        chk("rst_pin_out", 0, rst_out);
        n = 0;
        while (sys_reset_n !== 1'b1 && n < 300) begin
            @(posedge ref_clk);
            n++;
        end
        chk("sys_reset_n", 1, sys_reset_n);
        repeat (2) @(posedge ref_clk);
        chk("cpu_halt", halt, cpu_halt);
        chk("vector_fetch", !halt, vf_n - v0);
        apb(1'b0, `RMSC_ADDR_CAUSE, 32'h0);
        chk("cause", {24'h0, cause}, q);
    endtask

    task por(input logic ms);
        hold_ms <= ms;
        reset_n <= 1'b0;
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'b1;
        wait_rst(8'h80, ms);
        hold_ms <= 1'b0;
    endtask

    task automatic tx(input logic v, input int p);
        int l0, s0, w;
        l0 = low_n;
        s0 = spd_n;
        w = v ? 4 * p : 13 * p;
        apb(1'b1, `RMSC_ADDR_BDCTX, {31'h0, v});
        repeat (11 * p) @(posedge ref_clk);
        apb(1'b0, `RMSC_ADDR_BDCTX, 32'h0);
        chk("tx_busy", 1, q[1]);
        repeat (8 * p) @(posedge ref_clk);
        apb(1'b0, `RMSC_ADDR_BDCTX, 32'h0);
        chk("tx_idle", 0, q[1]);
        chk("low_len", 1, low_n - l0 >= w - p && low_n - l0 <= w + p);
        chk("speedup", 1, spd_n > s0);
    endtask

    task results;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge ref_clk);
        fails++;
        results();
    end

    // -----------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------
    initial begin
        reset_n = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        rst_req = '0;
        {bdc_bg, bdc_go, pull_rst, hold_ms} = '0;
        cz = '{8'h20, 8'h10, 8'h08, 8'h02};
        por(1'b0);
        chk("vector_addr", 32'hfffe, vector_addr);
        chk("ext_clk_off", 0, clk_src_ext);
        for (int i = 0; i < 4; i++) begin
            b = bus_clk;
            @(posedge ref_clk);
            chk("bus_clk", !b, bus_clk);
        end
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped_err", 1, e);
        chk("unmapped_data", 0, q);
        $display("test power_on done");
        apb(1'b1, `RMSC_ADDR_CTRL, 32'h1);
        @(posedge ref_clk);
        chk("ext_clk_on", 1, clk_src_ext);
        tx(1'b1, 2);
        tx(1'b0, 2);
        apb(1'b1, `RMSC_ADDR_CTRL, 32'h3);
        tx(1'b1, 4);
        $display("test debug_bits done");
        hold_ms <= 1'b1;
        apb(1'b1, `RMSC_ADDR_FORCE, 32'h1);
        wait_rst(8'h04, 1'b1);
        hold_ms <= 1'b0;
        chk("ext_clk_reset", 0, clk_src_ext);
        apb(1'b0, `RMSC_ADDR_CTRL, 32'h0);
        chk("ctrl_bg", 32'h4, q);
        bdc_go <= 1'b1;
        @(posedge ref_clk);
        bdc_go <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk("go_runs", 0, cpu_halt);
        bdc_bg <= 1'b1;
        @(posedge ref_clk);
        bdc_bg <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk("bg_halts", 1, cpu_halt);
        $display("test force done");
        hold_ms <= 1'b1;
        pull_rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        pull_rst <= 1'b0;
        wait_rst(8'h40, 1'b0);
        hold_ms <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk);
            rst_req <= rmsc_rst_req_t'(4'b1000 >> i);
            @(posedge ref_clk);
            rst_req <= '0;
            wait_rst(cz[i], 1'b0);
        end
        $display("test pin_and_internal done");
        por(1'b1);
        $display("test power_on_background done");
        results();
    end
endmodule

`default_nettype wire
